// ---- hw/khci_interp.v ----
// Functional notes
// (RULE1) Put-mode 0x14 operand 0..127 stores first constant high part; default 5.
// (RULE2) First constant equals high part times 256 plus low part.
// (RULE3) Put-mode 0x15 operand stores first constant low part; default 0xE9.
// (RULE4) Put-mode 0x16 operand stores second constant; default 8; global.
// (RULE5) New constants take effect only at reset or recalibration of all.
// (RULE6) Get-mode 0x14..0x17 return one byte of the stored setting.
// (RULE7) Put-mode 0x17 operand 0 or 1 turns noise sync off or on.
// (RULE8) Noise sync setting takes effect only after a reset.
// (RULE9) Setup writes are refused unless put direction is selected.
// (RULE10) 0x67 selects get direction, echoes 0x67; get after startup.
// (RULE11) 0x70 selects put direction, echoes 0x70.
// (RULE12) 0x73 plus key 0..0x3F scopes one key; echoes 0x73.
// (RULE13) 0x53 scopes all keys; echoes 0x53.
// (RULE14) 0x78 plus row 0..7 scopes that row; echoes 0x78.
// (RULE15) 0x79 plus column 0..7 scopes that column; echoes 0x79.
// (RULE16) 0x30..0x35 return one byte of the scoped key's quantity.
// (RULE17) 0x20..0x25 stream 8 or 64 bytes for row, column or all scope.
// (RULE18) 0x36 returns the setup memory checksum regardless of scope.
// (RULE19) 0x37 returns device status limited to five bits.
// (RULE20) 0x65 returns key error code 0..0x0F; 0x45 streams error bytes.
// (RULE21) 0x6B returns the first touched key; 0x4B streams touch bytes.
// (RULE22) 0x72 needs a null within 100 ms; echo, then reset 16 ms later.
// (RULE23) Pending command held until its operand byte arrives.
// (RULE24) Out-of-range operands leave the stored setting unchanged.
`include "khci_defs.vh"
`default_nettype none

module khci_interp #(
	parameter [19:0] NULL_WAIT_CYC = `KHCI_NULL_WAIT_CYC,
	parameter [19:0] RST_DELAY_CYC = `KHCI_RST_DELAY_CYC
) (
	input  wire        clk_sys,
	input  wire        resetn,
	input  wire        clkEn,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        linkClk,
	input  wire        linkSelN,
	input  wire        linkDin,
	output reg         linkDout,
	output reg         linkDoutOe,
	output reg         noiseSync,
	output reg  [14:0] boundFirst,
	output reg  [7:0]  boundSecond,
	output reg         softReset
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_OPND = 4'b0010;
	localparam [3:0] ST_STRM = 4'b0100;
	localparam [3:0] ST_RWT  = 4'b1000;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [5:0] keyOf;
		input [2:0] kind;
		input [5:0] idx;
		input [5:0] n;
		begin
			case (kind)
				`KHCI_SC_ROW: keyOf = {idx[2:0], n[2:0]};
				`KHCI_SC_COL: keyOf = {n[2:0], idx[2:0]};
				`KHCI_SC_ALL: keyOf = n;
				default:      keyOf = idx;
			endcase
		end
	endfunction

	function [6:0] countOf;
		input [2:0] kind;
		begin
			case (kind)
				`KHCI_SC_KEY: countOf = 7'h01;
				`KHCI_SC_ROW: countOf = 7'h08;
				`KHCI_SC_COL: countOf = 7'h08;
				`KHCI_SC_ALL: countOf = 7'h40;
				default:      countOf = 7'h00;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Link input synchronisers
	// ----------------------------------------
	reg [2:0] syncA_r;
	reg [2:0] syncB_r;
	reg       clkPrev_r;
	wire      sClk  = syncB_r[0];
	wire      sSelN = syncB_r[1];
	wire      sDin  = syncB_r[2];
	wire      clkRise = sClk & ~clkPrev_r;
	wire      clkFall = ~sClk & clkPrev_r;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			syncA_r   <= 3'h2;
			syncB_r   <= 3'h2;
			clkPrev_r <= 1'b0;
		end else if (clkEn) begin
			syncA_r   <= {linkDin, linkSelN, linkClk};
			syncB_r   <= syncA_r;
			clkPrev_r <= sClk;
		end
	end

	// ----------------------------------------
	// Byte shifter, mode 0, MSB first
	// ----------------------------------------
	reg [2:0] bitCnt_r;
	reg [7:0] rxSh_r;
	reg [7:0] txSh_r;
	reg [7:0] txByte_r;
	reg       rxStb_r;
	reg [7:0] rxByte_r;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bitCnt_r   <= 3'h0;
			rxSh_r     <= 8'h00;
			txSh_r     <= 8'h00;
			rxStb_r    <= 1'b0;
			rxByte_r   <= 8'h00;
			linkDout   <= 1'b0;
			linkDoutOe <= 1'b0;
		end else if (clkEn) begin
			rxStb_r    <= 1'b0;
			linkDout   <= txSh_r[7];
			linkDoutOe <= ~sSelN;
			if (sSelN) begin
				bitCnt_r <= 3'h0;
				txSh_r   <= txByte_r;
			end else if (clkRise) begin
				rxSh_r   <= {rxSh_r[6:0], sDin};
				bitCnt_r <= bitCnt_r + 3'h1;
				if (bitCnt_r == 3'h7) begin
					rxStb_r  <= 1'b1;
					rxByte_r <= {rxSh_r[6:0], sDin};
				end
			end else if (clkFall && bitCnt_r != 3'h0) begin
				txSh_r <= {txSh_r[6:0], 1'b0};
			end else if (bitCnt_r == 3'h0) begin
				txSh_r <= txByte_r;
			end
		end
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	reg  [7:0] keyMem [0:511];
	reg  [8:0] keyAdr_r;
	reg  [4:0] devStat_r;
	reg  [7:0] cksum_r;
	reg  [7:0] firstKey_r;
	reg        recalAll_r;
	wire       wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       wbWr  = wbReq & wb_we_i;

	always @(posedge clk_sys) begin
		if (clkEn && wbWr && wb_adr_i == `KHCI_REG_KDAT && wb_sel_i[0])
			keyMem[keyAdr_r] <= wb_dat_i[7:0];
	end

	reg        putMode_r;
	reg [2:0]  scopeKind_r;
	reg [5:0]  scopeIdx_r;
	reg [3:0]  state_r;
	reg [6:0]  c1Hi_r;
	reg [7:0]  c1Lo_r;
	reg [7:0]  c2_r;
	reg        nsync_r;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h0000_0000;
			keyAdr_r   <= 9'h000;
			devStat_r  <= 5'h00;
			cksum_r    <= 8'h00;
			firstKey_r <= 8'h00;
			recalAll_r <= 1'b0;
		end else if (clkEn) begin
			wb_ack_o   <= wbReq;
			recalAll_r <= 1'b0;
			if (wbWr) begin
				case (wb_adr_i)
					`KHCI_REG_CTRL:
						if (wb_sel_i[0])
							recalAll_r <= wb_dat_i[0];
					`KHCI_REG_KADR:
						if (wb_sel_i[0] && wb_sel_i[1])
							keyAdr_r <= wb_dat_i[8:0];
					`KHCI_REG_KDAT:
						if (wb_sel_i[0])
							keyAdr_r <= keyAdr_r + 9'h001;
					`KHCI_REG_DEV: begin
						if (wb_sel_i[0])
							devStat_r <= wb_dat_i[4:0];
						if (wb_sel_i[1])
							cksum_r <= wb_dat_i[15:8];
						if (wb_sel_i[2])
							firstKey_r <= wb_dat_i[23:16];
					end
					default: ;
				endcase
			end
			if (wbReq && !wb_we_i) begin
				case (wb_adr_i)
					`KHCI_REG_STAT:
						wb_dat_o <= {14'h0000, noiseSync, nsync_r,
							1'b0, c2_r[0], state_r, scopeIdx_r,
							scopeKind_r, putMode_r};
					`KHCI_REG_BOUND:
						wb_dat_o <= {8'h00, boundSecond, 1'b0,
							boundFirst};
					`KHCI_REG_KADR:
						wb_dat_o <= {23'h000000, keyAdr_r};
					`KHCI_REG_KDAT:
						wb_dat_o <= {24'h000000, keyMem[keyAdr_r]};
					`KHCI_REG_DEV:
						wb_dat_o <= {8'h00, firstKey_r, cksum_r,
							3'h0, devStat_r};
					default:
						wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Command interpreter
	// ----------------------------------------
	reg  [7:0]  pend_r;
	reg  [2:0]  strmQ_r;
	reg  [6:0]  strmN_r;
	reg  [6:0]  strmCnt_r;
	reg  [19:0] timer_r;
	wire [7:0]  b = rxByte_r;
	wire [6:0]  grpCnt = countOf(scopeKind_r);
	wire        isGrp = (b >= `KHCI_CMD_GRP_LO && b <= `KHCI_CMD_GRP_HI) ||
		b == `KHCI_CMD_ERRG || b == `KHCI_CMD_TOUCHG;
	wire [2:0]  grpQ = (b == `KHCI_CMD_ERRG) ? `KHCI_Q_ERR :
		(b == `KHCI_CMD_TOUCHG) ? `KHCI_Q_TOUCH : b[2:0];
	wire        isSet = b >= `KHCI_CMD_C1HI && b <= `KHCI_CMD_NSYNC;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r     <= ST_IDLE;
			putMode_r   <= 1'b0;
			scopeKind_r <= `KHCI_SC_NONE;
			scopeIdx_r  <= 6'h00;
			c1Hi_r      <= `KHCI_C1HI_RST;
			c1Lo_r      <= `KHCI_C1LO_RST;
			c2_r        <= `KHCI_C2_RST;
			nsync_r     <= 1'b0;
			noiseSync   <= 1'b0;
			boundFirst  <= {`KHCI_C1HI_RST, `KHCI_C1LO_RST};
			boundSecond <= `KHCI_C2_RST;
			softReset   <= 1'b0;
			txByte_r    <= 8'h00;
			pend_r      <= 8'h00;
			strmQ_r     <= 3'h0;
			strmN_r     <= 7'h00;
			strmCnt_r   <= 7'h00;
			timer_r     <= 20'h00000;
		end else if (clkEn) begin
			softReset <= 1'b0;
			if (recalAll_r) begin
				boundFirst  <= {c1Hi_r, c1Lo_r}; // [RULE2] [RULE5]
				boundSecond <= c2_r; // [RULE5]
			end
			if (timer_r != 20'h00000)
				timer_r <= timer_r - 20'h00001;
			case (state_r)
				ST_IDLE:
					if (rxStb_r) begin
						txByte_r <= `KHCI_ZERO_BYTE;
						if (b == `KHCI_CMD_GET) begin
							putMode_r <= 1'b0; // [RULE10]
							txByte_r  <= b;
						end else if (b == `KHCI_CMD_PUT) begin
							putMode_r <= 1'b1; // [RULE11]
							txByte_r  <= b;
						end else if (b == `KHCI_CMD_ALL) begin
							scopeKind_r <= `KHCI_SC_ALL; // [RULE13]
							txByte_r    <= b;
						end else if (b == `KHCI_CMD_KEY ||
							b == `KHCI_CMD_ROW || b == `KHCI_CMD_COL) begin
							pend_r  <= b; // [RULE23]
							state_r <= ST_OPND;
						end else if (isSet && putMode_r) begin
							pend_r  <= b; // [RULE9] [RULE23]
							state_r <= ST_OPND;
						end else if (isSet) begin
							case (b[1:0]) // [RULE6]
								2'h0: txByte_r <= {1'b0, c1Hi_r};
								2'h1: txByte_r <= c1Lo_r;
								2'h2: txByte_r <= c2_r;
								default: txByte_r <= {7'h00, nsync_r};
							endcase
						end else if (b == `KHCI_CMD_RESET && putMode_r) begin
							pend_r  <= b; // [RULE22]
							timer_r <= NULL_WAIT_CYC;
							state_r <= ST_OPND;
						end else if (b >= `KHCI_CMD_ONE_LO &&
							b <= `KHCI_CMD_ONE_HI) begin
							if (scopeKind_r == `KHCI_SC_KEY) // [RULE16]
								txByte_r <= keyMem[{b[2:0], scopeIdx_r}];
						end else if (b == `KHCI_CMD_ERR1) begin
							if (scopeKind_r == `KHCI_SC_KEY) // [RULE20]
								txByte_r <= `KHCI_ERR_MASK &
									keyMem[{`KHCI_Q_ERR, scopeIdx_r}];
						end else if (b == `KHCI_CMD_CKSUM) begin
							txByte_r <= cksum_r; // [RULE18]
						end else if (b == `KHCI_CMD_DSTAT) begin
							txByte_r <= `KHCI_DSTAT_MASK &
								{3'h0, devStat_r}; // [RULE19]
						end else if (b == `KHCI_CMD_FIRST) begin
							txByte_r <= firstKey_r; // [RULE21]
						end else if (isGrp && grpCnt != 7'h00) begin
							// [RULE17] [RULE20] [RULE21]
							txByte_r  <= keyMem[{grpQ,
								keyOf(scopeKind_r, scopeIdx_r, 6'h00)}];
							strmQ_r   <= grpQ;
							strmN_r   <= 7'h01;
							strmCnt_r <= grpCnt;
							if (grpCnt != 7'h01)
								state_r <= ST_STRM;
						end
					end
				ST_OPND:
					if (rxStb_r) begin
						txByte_r <= pend_r; // [RULE12] [RULE14] [RULE15]
						state_r  <= ST_IDLE;
						case (pend_r)
							`KHCI_CMD_KEY:
								if (b <= `KHCI_KEY_MAX) begin // [RULE24]
									scopeKind_r <= `KHCI_SC_KEY;
									scopeIdx_r  <= b[5:0]; // [RULE12]
								end
							`KHCI_CMD_ROW:
								if (b <= `KHCI_LINE_MAX) begin // [RULE24]
									scopeKind_r <= `KHCI_SC_ROW;
									scopeIdx_r  <= b[5:0]; // [RULE14]
								end
							`KHCI_CMD_COL:
								if (b <= `KHCI_LINE_MAX) begin // [RULE24]
									scopeKind_r <= `KHCI_SC_COL;
									scopeIdx_r  <= b[5:0]; // [RULE15]
								end
							`KHCI_CMD_C1HI:
								if (b <= `KHCI_C1HI_MAX) // [RULE24]
									c1Hi_r <= b[6:0]; // [RULE1]
							`KHCI_CMD_C1LO:
								c1Lo_r <= b; // [RULE3]
							`KHCI_CMD_C2:
								c2_r <= b; // [RULE4]
							`KHCI_CMD_NSYNC:
								if (b <= `KHCI_NSYNC_MAX) // [RULE24]
									nsync_r <= b[0]; // [RULE7]
							`KHCI_CMD_RESET:
								if (b == `KHCI_ZERO_BYTE &&
									timer_r != 20'h00000) begin // [RULE22]
									timer_r <= RST_DELAY_CYC;
									state_r <= ST_RWT;
								end else begin
									txByte_r <= `KHCI_ZERO_BYTE;
								end
							default: ;
						endcase
					end else if (pend_r == `KHCI_CMD_RESET &&
						timer_r == 20'h00000) begin
						state_r <= ST_IDLE; // [RULE22]
					end
				ST_STRM:
					if (rxStb_r) begin
						txByte_r <= keyMem[{strmQ_r, keyOf(scopeKind_r,
							scopeIdx_r, strmN_r[5:0])}]; // [RULE17]
						strmN_r  <= strmN_r + 7'h01;
						if (strmN_r + 7'h01 == strmCnt_r)
							state_r <= ST_IDLE;
					end
				ST_RWT:
					if (timer_r == 20'h00000) begin // [RULE22]
						softReset   <= 1'b1;
						noiseSync   <= nsync_r; // [RULE8]
						boundFirst  <= {c1Hi_r, c1Lo_r}; // [RULE2] [RULE5]
						boundSecond <= c2_r; // [RULE5]
						putMode_r   <= 1'b0;
						scopeKind_r <= `KHCI_SC_NONE;
						txByte_r    <= `KHCI_ZERO_BYTE;
						state_r     <= ST_IDLE;
					end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- hw/khci_defs.vh ----
`ifndef KHCI_DEFS_VH
`define KHCI_DEFS_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define KHCI_CMD_GET     8'h67
`define KHCI_CMD_PUT     8'h70
`define KHCI_CMD_KEY     8'h73
`define KHCI_CMD_ALL     8'h53
`define KHCI_CMD_ROW     8'h78
`define KHCI_CMD_COL     8'h79
`define KHCI_CMD_C1HI    8'h14
`define KHCI_CMD_C1LO    8'h15
`define KHCI_CMD_C2      8'h16
`define KHCI_CMD_NSYNC   8'h17
`define KHCI_CMD_RESET   8'h72
`define KHCI_CMD_ONE_LO  8'h30
`define KHCI_CMD_ONE_HI  8'h35
`define KHCI_CMD_CKSUM   8'h36
`define KHCI_CMD_DSTAT   8'h37
`define KHCI_CMD_GRP_LO  8'h20
`define KHCI_CMD_GRP_HI  8'h25
`define KHCI_CMD_ERR1    8'h65
`define KHCI_CMD_ERRG    8'h45
`define KHCI_CMD_FIRST   8'h6B
`define KHCI_CMD_TOUCHG  8'h4B

// ----------------------------------------
// Operand limits and reset values
// ----------------------------------------
`define KHCI_C1HI_MAX    8'h7F
`define KHCI_KEY_MAX     8'h3F
`define KHCI_LINE_MAX    8'h07
`define KHCI_NSYNC_MAX   8'h01
`define KHCI_C1HI_RST    7'h05
`define KHCI_C1LO_RST    8'hE9
`define KHCI_C2_RST      8'h08
`define KHCI_ERR_MASK    8'h0F
`define KHCI_DSTAT_MASK  8'h1F
`define KHCI_ZERO_BYTE   8'h00

// ----------------------------------------
// Key memory quantity selectors
// ----------------------------------------
`define KHCI_Q_ERR       3'h6
`define KHCI_Q_TOUCH     3'h7

// ----------------------------------------
// Scope kinds
// ----------------------------------------
`define KHCI_SC_NONE     3'h0
`define KHCI_SC_KEY      3'h1
`define KHCI_SC_ROW      3'h2
`define KHCI_SC_COL      3'h3
`define KHCI_SC_ALL      3'h4

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define KHCI_REG_CTRL    8'h00
`define KHCI_REG_STAT    8'h04
`define KHCI_REG_BOUND   8'h08
`define KHCI_REG_KADR    8'h0C
`define KHCI_REG_KDAT    8'h10
`define KHCI_REG_DEV     8'h14

// ----------------------------------------
// Timing
// ----------------------------------------
`define KHCI_NULL_WAIT_CYC 20'hF4240
`define KHCI_RST_DELAY_CYC 20'h27100

`endif

// ---- sim/khci_interp_properties.sv ----
`default_nettype none
module khci_interp_properties (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        clkEn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        linkClk,
	input wire logic        linkSelN,
	input wire logic        linkDin,
	input wire logic        linkDout,
	input wire logic        linkDoutOe,
	input wire logic        noiseSync,
	input wire logic [14:0] boundFirst,
	input wire logic [7:0]  boundSecond,
	input wire logic        softReset
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	logic recalTaken;
	assign recalTaken = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
		wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[0];

	sequence sTake;
		clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence sApply;
		$past(recalTaken) || $past(recalTaken, 2) || softReset ||
			$past(softReset) || $past(softReset, 2);
	endsequence

	AST_ACK_NEXT: assert property (sTake |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a one-cycle answer");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus ack without request");
	AST_RST_DEFAULTS: assert property ($rose(resetn) |->
		boundFirst == 15'h05E9 && boundSecond == 8'h08 && !noiseSync)
		else $error("applied settings wrong after reset");
	AST_FIRST_HOLD: assert property ($changed(boundFirst) |-> sApply)
		else $error("first constant applied without recalibration");
	AST_SECOND_HOLD: assert property ($changed(boundSecond) |-> sApply)
		else $error("second constant applied without recalibration");
	AST_NSYNC_HOLD: assert property ($changed(noiseSync) |->
		softReset || $past(softReset))
		else $error("noise sync applied without reset");
	AST_SOFT_PULSE: assert property (softReset |=> !softReset)
		else $error("soft reset longer than one cycle");
	AST_OE_SEL: assert property (!linkSelN [*4] |-> linkDoutOe)
		else $error("link output not enabled while selected");
	AST_OE_DESEL: assert property (linkSelN [*4] |-> !linkDoutOe)
		else $error("link output enabled while deselected");
endmodule

bind khci_interp khci_interp_properties u_props (
	.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .linkClk(linkClk),
	.linkSelN(linkSelN), .linkDin(linkDin), .linkDout(linkDout),
	.linkDoutOe(linkDoutOe), .noiseSync(noiseSync),
	.boundFirst(boundFirst), .boundSecond(boundSecond),
	.softReset(softReset));
`default_nettype wire

// ---- sim/khci_host_model.sv ----
`default_nettype none
module khci_host_model (
	output logic      linkClk,
	output logic      linkSelN,
	output logic      linkDin,
	input  wire logic linkDout
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		linkClk = 1'b0;
		linkSelN = 1'b1;
		linkDin = 1'b1;
	end

	// ----------------------------------------
	// One byte, mode 0, MSB first, 800 ns period
	// ----------------------------------------
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		// Byte spans whole clocks, so link edges keep clear of clk_sys edges
		#90;
		linkSelN = 1'b0;
		#800;
		for (int i = 7; i >= 0; i--) begin
			linkDin = tx[i];
			#400;
			linkClk = 1'b1;
			rx[i] = linkDout;
			#400;
			linkClk = 1'b0;
		end
		#400;
		linkSelN = 1'b1;
		// Released data line must not keep the last bit
		linkDin = ~linkDin;
		#710;
	endtask
endmodule
`default_nettype wire

// ---- sim/khci_interp_tb_top.sv ----
`define KCHK(nm, e, g) begin \
	checkCount++; \
	if ((g) !== (e)) begin \
		numErrors++; \
		$display("wrong value %s exp %h got %h", nm, e, g); \
	end \
end
`default_nettype none
module khci_interp_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        clkEn = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, linkClk, linkSelN, linkDin, linkDout;
	logic        linkDoutOe, noiseSync, softReset;
	logic [14:0] boundFirst;
	logic [7:0]  boundSecond;
	logic [7:0]  r;
	logic [31:0] d;
	int          numErrors = 0;
	int          checkCount = 0;
	int          softCnt = 0;

	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (softReset === 1'b1) softCnt++;

	khci_interp #(.NULL_WAIT_CYC(20'h00190), .RST_DELAY_CYC(20'h000C8)) u_dut (
		.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .linkClk(linkClk),
		.linkSelN(linkSelN), .linkDin(linkDin), .linkDout(linkDout),
		.linkDoutOe(linkDoutOe), .noiseSync(noiseSync),
		.boundFirst(boundFirst), .boundSecond(boundSecond),
		.softReset(softReset));
	khci_host_model u_host (.linkClk(linkClk), .linkSelN(linkSelN),
		.linkDin(linkDin), .linkDout(linkDout));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task say(input logic [7:0] b, input logic [7:0] e);
		logic [7:0] rx;
		u_host.xfer(b, rx);
		`KCHK("link reply", e, rx)
	endtask

	function automatic logic [7:0] ev(input logic [2:0] q, input logic [5:0] k);
		if (q == 3'h4)
			return 8'(k % 6'h03);
		if (q == 3'h6)
			return {k[1:0], 2'h0, k[3:0]};
		return {q, 5'h00} ^ {2'h0, k};
	endfunction

	task endOfTest;
		$display("checks %0d errors %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task tReset;
		`KCHK("boundFirst", 15'h05E9, boundFirst)
		`KCHK("noiseSync", 1'b0, noiseSync)
		`KCHK("linkDoutOe", 1'b0, linkDoutOe)
		// Request held while frozen: no answer until enable returns
		clkEn <= 1'b0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= 1'b0;
		wb_adr_i <= 8'h08;
		repeat (4) @(posedge clk_sys);
		`KCHK("frozen ack", 1'b0, wb_ack_o)
		clkEn <= 1'b1;
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		d = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		`KCHK("bound reg", 32'h000805E9, d & 32'h00FF7FFF)
		wb(1'b0, 8'hFC, 32'h0, d);
		`KCHK("unmapped", 32'h0, d)
		u_host.xfer(8'h14, r);
		say(8'h03, 8'h05);
		say(8'h15, 8'h00);
		say(8'h16, 8'hE9);
		say(8'h17, 8'h08);
		say(8'h14, 8'h00);
		say(8'h00, 8'h05);
	endtask

	task tSetup;
		u_host.xfer(8'h70, r);
		say(8'h14, 8'h70);
		say(8'h03, 8'h00);
		say(8'h15, 8'h14);
		say(8'h12, 8'h00);
		say(8'h16, 8'h15);
		say(8'h44, 8'h00);
		say(8'h14, 8'h16);
		say(8'h80, 8'h00);
		say(8'h17, 8'h14);
		say(8'h01, 8'h00);
		say(8'h17, 8'h17);
		say(8'h02, 8'h00);
		say(8'h67, 8'h17);
		say(8'h14, 8'h67);
		say(8'h15, 8'h03);
		say(8'h16, 8'h12);
		say(8'h17, 8'h44);
		say(8'h00, 8'h01);
		`KCHK("boundFirst", 15'h05E9, boundFirst)
		wb(1'b1, 8'h00, 32'h1, d);
		repeat (3) @(posedge clk_sys);
		`KCHK("boundFirst", 15'h0312, boundFirst)
		`KCHK("boundSecond", 8'h44, boundSecond)
		`KCHK("noiseSync", 1'b0, noiseSync)
	endtask

	task tScope;
		wb(1'b1, 8'h0C, 32'h0, d);
		for (int i = 0; i < 512; i++)
			wb(1'b1, 8'h10, {24'h0, ev(i[8:6], i[5:0])}, d);
		u_host.xfer(8'h73, r);
		say(8'h2A, 8'h00);
		say(8'h30, 8'h73);
		for (int c = 1; c < 6; c++)
			say(8'h30 + 8'(c), ev(3'(c - 1), 6'h2A));
		say(8'h65, ev(3'h5, 6'h2A));
		say(8'h45, ev(3'h6, 6'h2A) & 8'h0F);
		say(8'h00, ev(3'h6, 6'h2A));
		u_host.xfer(8'h78, r);
		say(8'h05, 8'h00);
		for (int c = 0; c < 6; c++) begin
			u_host.xfer(8'h20 + 8'(c), r);
			if (c == 0)
				`KCHK("row echo", 8'h78, r)
			for (int n = 0; n < 8; n++)
				say(8'h00, ev(3'(c), 6'(40 + n)));
		end
		u_host.xfer(8'h79, r);
		say(8'h02, 8'h00);
		say(8'h45, 8'h79);
		for (int n = 0; n < 8; n++)
			say(8'h00, ev(3'h6, 6'(n * 8 + 2)));
		u_host.xfer(8'h53, r);
		say(8'h4B, 8'h53);
		for (int n = 0; n < 64; n++)
			say(8'h00, ev(3'h7, 6'(n)));
	endtask

	task tDev;
		wb(1'b1, 8'h14, 32'h002A5CF3, d);
		wb(1'b0, 8'h14, 32'h0, d);
		`KCHK("dev reg", 32'h002A5C13, d)
		u_host.xfer(8'h36, r);
		say(8'h37, 8'h5C);
		say(8'h6B, 8'h13);
		say(8'h00, 8'h2A);
	endtask

	task tSoft;
		int c0;
		int n;
		c0 = softCnt;
		u_host.xfer(8'h70, r);
		say(8'h72, 8'h70);
		repeat (500) @(posedge clk_sys);
		u_host.xfer(8'h00, r);
		u_host.xfer(8'h00, r);
		repeat (250) @(posedge clk_sys);
		`KCHK("late null", c0, softCnt)
		u_host.xfer(8'h72, r);
		u_host.xfer(8'h00, r);
		say(8'h00, 8'h72);
		n = 0;
		while (softCnt == c0 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		`KCHK("soft reset", c0 + 1, softCnt)
		repeat (3) @(posedge clk_sys);
		`KCHK("noiseSync", 1'b1, noiseSync)
		u_host.xfer(8'h17, r);
		say(8'h00, 8'h01);
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		tReset();
		tSetup();
		tScope();
		tDev();
		tSoft();
		endOfTest();
	end

	initial begin
		#4000000;
		numErrors++;
		endOfTest();
	end
endmodule
`default_nettype wire
